// >>> hw/dswc_pkg.sv
// Package for the single-mode DMA wait control block: register map, field layout,
// reset values, state counts and the cycle sequencer states.
// Assumes one bus state per sys_clk cycle and a plain strobe register port.
`default_nettype none

package dswc_pkg;

	// Register indexes on the local register port
	localparam int unsigned REG_ADDR_W = 2;
	localparam logic [1:0] REG_WAIT_CTRL = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_LAST_CYCLE = 2'h2;

	// Control register layout and reset value
	localparam int unsigned CTRL_W = 16;
	localparam logic [15:0] WAIT_CTRL_RESET = 16'hFFFF;
	localparam int unsigned READ_BITS_LSB = 8;
	localparam int unsigned WRITE_BITS_LSB = 0;
	localparam int unsigned AREA_COUNT = 8;

	// Areas with special treatment
	localparam logic [2:0] AREA0 = 3'h0;
	localparam logic [2:0] AREA1 = 3'h1;
	localparam logic [2:0] AREA2 = 3'h2;
	localparam logic [2:0] AREA6 = 3'h6;

	// Base state counts of one single-mode DMA bus cycle
	localparam int unsigned STATE_CNT_W = 4;
	localparam logic [3:0] STATES_ONE = 4'h1;
	localparam logic [3:0] STATES_TWO = 4'h2;
	localparam logic [3:0] STATES_MUX_IO = 4'h4;

	// Status register layout
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_WAIT_BIT = 1;
	localparam int unsigned STAT_SAMPLE_BIT = 2;
	localparam int unsigned STAT_WRITE_BIT = 3;
	localparam int unsigned STAT_AREA_LSB = 4;

	// Last-cycle register layout; both counts saturate at 8'hFF
	localparam int unsigned LAST_TOTAL_LSB = 0;
	localparam int unsigned LAST_WAITS_LSB = 8;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_FIRST_STATE = 8'h01;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

	// Idle level of the active-low wait pin
	localparam logic WAIT_PIN_IDLE = 1'b1;

	typedef enum logic [1:0] {
		FSM_IDLE = 2'b00,
		FSM_BASE = 2'b01,
		FSM_WAIT = 2'b10
	} dswc_fsm_t;

endpackage

`default_nettype wire

// >>> hw/dswc_sync.sv
// Two flip-flop synchroniser for a single level from outside the sys_clk domain.
// Assumes the input is a slow level such as an external wait request.
`timescale 1ns/10ps
`default_nettype none

module dswc_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	typedef struct packed {
		logic meta;
		logic stable;
	} dswc_sync_state_t;

	dswc_sync_state_t s;
	dswc_sync_state_t next_s;

	// The first stage feeds only the second one
	always_comb begin
		next_s = s;
		next_s.meta = async_in;
		next_s.stable = s.meta;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{meta: RESET_LEVEL, stable: RESET_LEVEL};
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stable;

endmodule

`default_nettype wire

// >>> hw/dswc_wait_ctrl.sv
// Single-mode DMA wait-state control: the per-area control register, the decode
// of a cycle's state count and wait sampling, and the state sequencer.
// Assumes a DMA controller that raises cyc_start for one cycle per bus cycle,
// long-wait fields from a neighbouring register, and one bus state per clock.
//
// Behaviour
// [R1] Sixteen-bit read/write control register, all ones after power-on reset.
// [R2] Manual reset and standby leave the control register contents untouched.
// [R3] Settings apply to single-mode DMA bus cycles: state count and sampling per area.
// [R4] Bits 15..8 steer reads for areas 7..0; cleared bit stops wait sampling.
// [R5] Areas 1,3,4,5,7 external memory, cleared bit: cycle lasts one state.
// [R6] Areas 1,3,4,5,7 external memory, set bit: two states plus wait states.
// [R7] Areas 0,2,6, cleared bit: one state plus long wait, no sampling.
// [R8] Areas 0,2,6, set bit: one state plus long wait plus wait states.
// [R9] Area 1 as DRAM: column cycle one state if cleared, two plus waits if set.
// [R10] Area 6 multiplexed I/O: four states plus waits, whatever its bit holds.
// [R11] Multiplexed I/O cycles always sample the wait input.
// [R12] Bits 7..0 steer writes for areas 7..0; cleared bit stops wait sampling.
// [R13] Writes use the same state counts and sampling as reads for equal bits.
// [R14] Long wait comes from two-bit fields meaning one to four states.
// [R15] Each state with wait sampled low adds one state; high sample ends cycle.
// [R16] External parts hold wait low before each sample point they want extended.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

module dswc_wait_ctrl #(
	parameter int unsigned ADDR_W = dswc_pkg::REG_ADDR_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic manual_rst_n,
	input wire logic standby,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [1:0] long_delay_areas_0_2,
	input wire logic [1:0] long_delay_area_6,
	input wire logic cyc_start,
	input wire logic [2:0] cyc_area,
	input wire logic cyc_write,
	input wire logic cyc_dram,
	input wire logic cyc_mux_io,
	output logic cyc_ready,
	output logic cyc_busy,
	output logic cyc_wait_state,
	output logic cyc_sample_en,
	output logic cyc_last,
	input wire logic wait_n
);

	typedef struct packed {
		dswc_pkg::dswc_fsm_t fsm;
		logic [3:0] remain;
		logic sample;
		logic write;
		logic [2:0] area;
		logic [7:0] total;
		logic [7:0] waits;
		logic [7:0] last_total;
		logic [7:0] last_waits;
		logic [15:0] ctrl;
		logic [15:0] rdata;
	} dswc_main_state_t;

	localparam dswc_main_state_t STATE_RESET = '{
		fsm: dswc_pkg::FSM_IDLE,
		remain: 4'h0,
		sample: 1'b0,
		write: 1'b0,
		area: 3'h0,
		total: dswc_pkg::COUNT_RESET,
		waits: dswc_pkg::COUNT_RESET,
		last_total: dswc_pkg::COUNT_RESET,
		last_waits: dswc_pkg::COUNT_RESET,
		ctrl: dswc_pkg::WAIT_CTRL_RESET,
		rdata: 16'h0000
	};

	dswc_main_state_t s;
	dswc_main_state_t next_s;

	logic wait_sync_n;
	logic wait_low;
	logic take;
	logic sel_bit;
	logic [4:0] plan;
	logic last_state;
	logic [15:0] status_word;
	logic [15:0] last_word;

	// Long-wait field to inserted state count: 0..3 means 1..4 states
	function automatic logic [3:0] long_wait_states(input logic [1:0] field);
		return {2'h0, field} + dswc_pkg::STATES_ONE; // [R14]
	endfunction

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == dswc_pkg::COUNT_MAX) ? v : v + 8'h01;
	endfunction

	// Returns {sample_enable, base_state_count} for one cycle
	function automatic logic [4:0] cycle_plan(
		input logic [2:0] area,
		input logic bit_set,
		input logic dram,
		input logic mux_io,
		input logic [1:0] lw02,
		input logic [1:0] lw6
	);
		logic [3:0] lw;
		lw = (area == dswc_pkg::AREA6) ? long_wait_states(lw6) : long_wait_states(lw02);
		if (area == dswc_pkg::AREA6 && mux_io) begin
			// The control bit has no say here
			return {1'b1, dswc_pkg::STATES_MUX_IO}; // [R10] [R11]
		end else if (area == dswc_pkg::AREA1 && dram) begin
			// Long pitch when set, short pitch when cleared
			return bit_set ? {1'b1, dswc_pkg::STATES_TWO} : {1'b0, dswc_pkg::STATES_ONE}; // [R9]
		end else if (area == dswc_pkg::AREA0 || area == dswc_pkg::AREA2 ||
				area == dswc_pkg::AREA6) begin
			return {bit_set, dswc_pkg::STATES_ONE + lw}; // [R7] [R8]
		end else begin
			return bit_set ? {1'b1, dswc_pkg::STATES_TWO} : {1'b0, dswc_pkg::STATES_ONE}; // [R5] [R6]
		end
	endfunction

	// The wait pin is asynchronous to the bus clock; two states of latency result
	dswc_sync #(
		.RESET_LEVEL(dswc_pkg::WAIT_PIN_IDLE)
	) u_wait_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(wait_n),
		.sync_out(wait_sync_n)
	);

	assign wait_low = ~wait_sync_n;

	// Standby and manual reset hold off new cycles but not the register port
	assign cyc_ready = (s.fsm == dswc_pkg::FSM_IDLE) & ~standby & manual_rst_n;
	assign take = cyc_start & cyc_ready;

	// Read bits for reads, write bits for writes, one decode for both
	assign sel_bit = cyc_write ? s.ctrl[dswc_pkg::WRITE_BITS_LSB + cyc_area] :
		s.ctrl[dswc_pkg::READ_BITS_LSB + cyc_area]; // [R4] [R12] [R13]

	assign plan = cycle_plan(cyc_area, sel_bit, cyc_dram, cyc_mux_io,
		long_delay_areas_0_2, long_delay_area_6); // [R3]

	always_comb begin
		status_word = 16'h0000;
		status_word[dswc_pkg::STAT_BUSY_BIT] = (s.fsm != dswc_pkg::FSM_IDLE);
		status_word[dswc_pkg::STAT_WAIT_BIT] = (s.fsm == dswc_pkg::FSM_WAIT);
		status_word[dswc_pkg::STAT_SAMPLE_BIT] = s.sample;
		status_word[dswc_pkg::STAT_WRITE_BIT] = s.write;
		status_word[dswc_pkg::STAT_AREA_LSB +: 3] = s.area;
		last_word = 16'h0000;
		last_word[dswc_pkg::LAST_TOTAL_LSB +: 8] = s.last_total;
		last_word[dswc_pkg::LAST_WAITS_LSB +: 8] = s.last_waits;
	end

	always_comb begin
		next_s = s;
		last_state = 1'b0;
		case (s.fsm)
			dswc_pkg::FSM_IDLE: begin
				if (take) begin
					next_s.fsm = dswc_pkg::FSM_BASE;
					next_s.remain = plan[3:0];
					next_s.sample = plan[4];
					next_s.write = cyc_write;
					next_s.area = cyc_area;
					next_s.total = dswc_pkg::COUNT_FIRST_STATE;
					next_s.waits = dswc_pkg::COUNT_RESET;
				end
			end
			dswc_pkg::FSM_BASE: begin
				if (s.remain > dswc_pkg::STATES_ONE) begin
					next_s.remain = s.remain - 4'h1;
					next_s.total = sat_inc(s.total);
				end else if (s.sample && wait_low) begin
					// Wait only looked at in the last base state
					next_s.fsm = dswc_pkg::FSM_WAIT; // [R15]
					next_s.remain = 4'h0;
					next_s.waits = sat_inc(s.waits);
					next_s.total = sat_inc(s.total);
				end else begin
					last_state = 1'b1;
					next_s.fsm = dswc_pkg::FSM_IDLE;
					next_s.remain = 4'h0;
					next_s.last_total = s.total;
					next_s.last_waits = s.waits;
				end
			end
			dswc_pkg::FSM_WAIT: begin
				// No upper bound: a wait held low forever stalls the cycle
				if (wait_low) begin
					next_s.waits = sat_inc(s.waits); // [R15] [R16]
					next_s.total = sat_inc(s.total);
				end else begin
					last_state = 1'b1; // [R15]
					next_s.fsm = dswc_pkg::FSM_IDLE;
					next_s.last_total = s.total;
					next_s.last_waits = s.waits;
				end
			end
			default: begin
				next_s.fsm = dswc_pkg::FSM_IDLE;
				next_s.remain = 4'h0;
			end
		endcase

		// Manual reset aborts the cycle in flight but keeps the settings
		if (!manual_rst_n) begin
			last_state = 1'b0;
			next_s.fsm = dswc_pkg::FSM_IDLE;
			next_s.remain = 4'h0;
			next_s.sample = 1'b0;
		end

		// Written value steers the next cycle taken, not one already running
		if (reg_wr && reg_addr == ADDR_W'(dswc_pkg::REG_WAIT_CTRL)) begin
			next_s.ctrl = reg_wdata; // [R1]
		end

		next_s.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_W'(dswc_pkg::REG_WAIT_CTRL): begin
					next_s.rdata = s.ctrl; // [R1]
				end
				ADDR_W'(dswc_pkg::REG_STATUS): begin
					next_s.rdata = status_word;
				end
				ADDR_W'(dswc_pkg::REG_LAST_CYCLE): begin
					next_s.rdata = last_word;
				end
				default: begin
					next_s.rdata = 16'h0000;
				end
			endcase
		end
	end

	// Only the power-on reset loads the register; standby never reaches it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= STATE_RESET; // [R1] [R2]
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign cyc_busy = (s.fsm != dswc_pkg::FSM_IDLE);
	assign cyc_wait_state = (s.fsm == dswc_pkg::FSM_WAIT);
	assign cyc_sample_en = cyc_busy & s.sample; // [R4] [R12]
	assign cyc_last = last_state;

endmodule

`default_nettype wire

// >>> tb/dswc_mem_model.sv
// External memory model: holds the wait pin low for a set number of states.
// Assumes the bench arms it one state before the bus cycle is requested.
`timescale 1ns/10ps
`default_nettype none
module dswc_mem_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic [3:0] hold,
	output logic wait_n
);
	logic [3:0] cnt;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
		end else if (arm) begin
			cnt <= hold;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	// Low ahead of the sample points; released pin is pulled up
	assign wait_n = cnt == 4'h0;
endmodule
`default_nettype wire

// >>> tb/dswc_wait_ctrl_bench.sv
// Bench for dswc_wait_ctrl: register port and single-mode DMA cycle lengths.
// Assumes the checker is bound in and the memory model drives the wait pin.
`timescale 1ns/10ps
`default_nettype none
module dswc_wait_ctrl_bench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic manual_rst_n = 1'b1;
	logic standby = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] lw02 = 2'h3;
	logic [1:0] lw6 = 2'h0;
	logic cyc_start = 1'b0;
	logic [2:0] cyc_area = 3'h0;
	logic cyc_write = 1'b0;
	logic cyc_dram = 1'b0;
	logic cyc_mux_io = 1'b0;
	logic arm = 1'b0;
	logic [15:0] reg_rdata, v;
	logic cyc_ready, cyc_busy, cyc_wait_state, cyc_sample_en, cyc_last, wait_n;
	logic [15:0] pat [4] = '{16'h0000, 16'hFF00, 16'h00FF, 16'h0000};
	int n_fail = 0;
	int cmp_count = 0;
	always #2.5 sys_clk = ~sys_clk;
	dswc_wait_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .manual_rst_n(manual_rst_n),
		.standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .long_delay_areas_0_2(lw02),
		.long_delay_area_6(lw6), .cyc_start(cyc_start), .cyc_area(cyc_area),
		.cyc_write(cyc_write), .cyc_dram(cyc_dram), .cyc_mux_io(cyc_mux_io),
		.cyc_ready(cyc_ready), .cyc_busy(cyc_busy), .cyc_wait_state(cyc_wait_state),
		.cyc_sample_en(cyc_sample_en), .cyc_last(cyc_last), .wait_n(wait_n));
	dswc_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n), .arm(arm), .hold(4'h6),
		.wait_n(wait_n));
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// An edge passes so a following write never drives the strobe twice in one step
		@(posedge sys_clk);
	endtask
	// Data is taken mid-cycle so the registered update cannot race the read
	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
		check("reg_rdata", exp, v);
		@(posedge sys_clk);
	endtask
	function automatic logic [7:0] base(input int a, input logic b, input logic m);
		if (a == 6 && m) return 8'h04;
		if (a == 0 || a == 2) return 8'h02 + lw02;
		if (a == 6) return 8'h02 + lw6;
		return b ? 8'h02 : 8'h01;
	endfunction
	task automatic run(input int a, input logic w, input logic [7:0] b, input logic s);
		int k;
		arm <= 1'b1;
		@(posedge sys_clk);
		arm <= 1'b0;
		cyc_start <= 1'b1;
		cyc_area <= a[2:0];
		cyc_write <= w;
		@(posedge sys_clk);
		cyc_start <= 1'b0;
		for (k = 0; k < 40; k++) begin
			@(negedge sys_clk);
			if (cyc_busy === 1'b0) break;
		end
		if (k == 40) begin
			n_fail++;
			end_sim();
		end
		@(posedge sys_clk);
		reg_addr <= 2'h2;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
		check("total_states", {8'h00, b + v[15:8]}, {8'h00, v[7:0]});
		check("wait_sampled", {15'h0000, s}, {15'h0000, v[15:8] != 8'h00});
		@(posedge sys_clk);
	endtask
	initial begin
		int a;
		logic w, b, m;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(2'h0, 16'hFFFF);
		rd(2'h3, 16'h0000);
		wr(2'h0, 16'hA55A);
		wr(2'h1, 16'h1234);
		rd(2'h0, 16'hA55A);
		rd(2'h1, 16'h0000);
		// Standby and manual reset are checked apart, so each one's hold-off is seen
		standby <= 1'b1;
		@(negedge sys_clk);
		check("cyc_ready", 16'h0000, {15'h0000, cyc_ready});
		@(posedge sys_clk);
		standby <= 1'b0;
		manual_rst_n <= 1'b0;
		@(negedge sys_clk);
		check("cyc_ready", 16'h0000, {15'h0000, cyc_ready});
		@(posedge sys_clk);
		manual_rst_n <= 1'b1;
		@(negedge sys_clk);
		check("cyc_ready", 16'h0001, {15'h0000, cyc_ready});
		@(posedge sys_clk);
		rd(2'h0, 16'hA55A);
		for (int p = 0; p < 4; p++) begin
			wr(2'h0, pat[p]);
			m = p >= 2;
			cyc_dram <= m;
			cyc_mux_io <= m;
			for (int i = 0; i < 16; i++) begin
				a = i >> 1;
				w = i[0];
				b = pat[p][w ? a : a + 8];
				run(a, w, base(a, b, m), b | (a == 6 && m));
			end
		end
		cyc_area <= 3'h0;
		cyc_write <= 1'b0;
		cyc_start <= 1'b1;
		@(posedge sys_clk);
		cyc_start <= 1'b0;
		@(posedge sys_clk);
		manual_rst_n <= 1'b0;
		@(posedge sys_clk);
		manual_rst_n <= 1'b1;
		@(negedge sys_clk);
		check("cyc_busy", 16'h0000, {15'h0000, cyc_busy});
		@(posedge sys_clk);
		rd(2'h0, 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire

// >>> tb/dswc_wait_ctrl_chk.sv
// Checker for dswc_wait_ctrl: cycle length, wait sampling, register port.
// Assumes it is bound into every dswc_wait_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dswc_wait_ctrl_chk #(
	parameter int unsigned ADDR_W = 2
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic manual_rst_n,
	input wire logic standby,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0] long_delay_areas_0_2,
	input wire logic cyc_start,
	input wire logic [2:0] cyc_area,
	input wire logic cyc_write,
	input wire logic cyc_mux_io,
	input wire logic cyc_ready,
	input wire logic cyc_busy,
	input wire logic cyc_wait_state,
	input wire logic cyc_sample_en,
	input wire logic cyc_last
);
	logic [15:0] ctrl;
	logic go;
	logic on;
	logic grp;
	logic mux;
	// Shadow of the control register, so plans can be predicted here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 16'hFFFF;
		end else if (reg_wr && reg_addr == '0) begin
			ctrl <= reg_wdata;
		end
	end
	assign go = cyc_start && cyc_ready;
	assign on = ctrl[{!cyc_write, cyc_area}];
	assign grp = cyc_area inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
	assign mux = cyc_area == 3'h6 && cyc_mux_io;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !manual_rst_n);
	ready_rule_a: assert property (cyc_ready == (!cyc_busy && !standby))
		else $error("ready does not follow idle and standby");
	start_busy_a: assert property (go |=> cyc_busy)
		else $error("accepted start did not begin a cycle");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
	set_sample_a: assert property (go && on |=> cyc_sample_en)
		else $error("set bit but wait not sampled");
	clr_nosample_a: assert property (go && !on && !mux |=> !cyc_sample_en)
		else $error("cleared bit but wait sampled");
	one_state_a: assert property (go && grp && !on |=> cyc_last)
		else $error("short cycle not one state");
	two_state_a: assert property (go && grp && on |=> !cyc_last ##1 cyc_busy)
		else $error("long pitch cycle under two states");
	long_five_a: assert property (go && !on && cyc_area inside {3'h0, 3'h2}
		&& long_delay_areas_0_2 == 2'h3 |=> (!cyc_last)[*4] ##1 cyc_last)
		else $error("long wait cycle not five states");
	mux_io_a: assert property (go && mux |=> (cyc_sample_en && !cyc_last)[*3] ##1 cyc_busy)
		else $error("mux io cycle under four states or unsampled");
	wait_ok_a: assert property (cyc_wait_state |-> cyc_sample_en && cyc_busy)
		else $error("wait state without sampling");
	last_end_a: assert property (cyc_last |=> !cyc_busy)
		else $error("cycle ran past its last state");
	cover property (go && mux);
	cover property (cyc_wait_state);
	cover property (go && cyc_write && !on);
endmodule
bind dswc_wait_ctrl dswc_wait_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .manual_rst_n(manual_rst_n), .standby(standby),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .long_delay_areas_0_2(long_delay_areas_0_2),
	.cyc_start(cyc_start), .cyc_area(cyc_area), .cyc_write(cyc_write),
	.cyc_mux_io(cyc_mux_io), .cyc_ready(cyc_ready), .cyc_busy(cyc_busy),
	.cyc_wait_state(cyc_wait_state), .cyc_sample_en(cyc_sample_en), .cyc_last(cyc_last)
);
`default_nettype wire
